/* File: core/mhcp_port.v */
`timescale 1ns/1ns
`include "mhcp_regs.vh"
module mhcp_port (
  input wire CLK,              // 20 MHz system clock
  input wire RST,              // Sync reset, active high
  input wire ALE,              // Address latch strobe
  input wire CS_N,             // Chip select, active low
  input wire RD_N,             // Read strobe, active low
  input wire WR_N,             // Write strobe, active low
  input wire [7:0] BUS_I,      // Muxed bus lines in
  output reg [7:0] BUS_O,      // Muxed bus lines out
  output wire [7:0] BUS_OE,    // Bus drive enables
  input wire EXT_CLK,          // External timing clock
  input wire XTAL_CLK,         // Crystal echo source
  output wire CLK_OUT,         // Host clock output
  output wire INT_OE,          // Interrupt pulls low when high
  input wire [7:0] DET_IN,     // Live detect flags
  output wire HOOK_OE,         // Hook relay pulls low when high
  input wire TXD,              // Terminal transmit data
  output reg TXD_SAMPLE,       // Sampled transmit data
  output reg TX_BIT_CLK,       // Transmit bit clock
  input wire RX_BIT_IN,        // Demodulated receive bit
  output reg RXD,              // Receive data to terminal
  output reg RX_BIT_CLK,       // Receive bit clock
  output reg TONE_ON,          // Tone generator keyed
  output reg [3:0] TONE_CODE   // Selected tone pair
);
  reg [1:0] ale_s, cs_s, rd_s, wr_s, ex_s, xt_s, txd_s, rxb_s;
  reg [7:0] bus_s1, bus_s;
  reg ale_d, rd_d, wr_d, ex_d;
  reg [2:0] addr_r;
  reg csl_r;
  reg [7:0] sh_r;
  reg [3:0] cnt_r;
  reg int_r;
  reg [7:0] det_d;
  reg [15:0] div16_r, bit_r;
  reg clk16_r;
  wire [7:0] rdata, line_q, ifc_q, tone_q, gain_q;
  wire ale, cs_n, rd_n, wr_n, ex, serial;
  wire rd_fall, wr_rise, ex_fall, ex_rise, ale_fall;
  wire soft_clr, we, det_read;
  wire [2:0] raddr;
  wire [3:0] tmode;
  wire [7:0] wdata;
  wire [7:0] det_chg;
  // Two-flop synchronisers on every pin input except DET_IN and RST
  always @(posedge CLK) begin
    if (RST) begin
      ale_s <= 2'h0;
      cs_s <= 2'h3;
      rd_s <= 2'h3;
      wr_s <= 2'h3;
      ex_s <= 2'h0;
      xt_s <= 2'h0;
      txd_s <= 2'h3;
      rxb_s <= 2'h3;
      bus_s1 <= 8'h00;
      bus_s <= 8'h00;
    end else begin
      ale_s <= {ale_s[0], ALE};
      cs_s <= {cs_s[0], CS_N};
      rd_s <= {rd_s[0], RD_N};
      wr_s <= {wr_s[0], WR_N};
      ex_s <= {ex_s[0], EXT_CLK};
      xt_s <= {xt_s[0], XTAL_CLK};
      txd_s <= {txd_s[0], TXD};
      rxb_s <= {rxb_s[0], RX_BIT_IN};
      bus_s1 <= BUS_I;
      bus_s <= bus_s1;
    end
  end
  assign ale = ale_s[1];
  assign cs_n = cs_s[1];
  assign rd_n = rd_s[1];
  assign wr_n = wr_s[1];
  assign ex = ex_s[1];
  always @(posedge CLK) begin
    if (RST) begin
      ale_d <= 1'b0;
      rd_d <= 1'b1;
      wr_d <= 1'b1;
      ex_d <= 1'b0;
    end else begin
      ale_d <= ale;
      rd_d <= rd_n;
      wr_d <= wr_n;
      ex_d <= ex;
    end
  end
  assign ale_fall = ale_d & ~ale;
  assign rd_fall = rd_d & ~rd_n;
  assign wr_rise = ~wr_d & wr_n;
  assign ex_fall = ex_d & ~ex;
  assign ex_rise = ~ex_d & ex;
  assign serial = ale & ~cs_n;
  always @(posedge CLK) begin
    if (RST) begin
      addr_r <= 3'h0;
      csl_r <= 1'b1;
    end else if (ale_fall) begin
      addr_r <= bus_s[2:0];
      csl_r <= cs_n;
    end
  end
  // serial address read live from the select lines
  assign raddr = serial ? bus_s[2:0] : addr_r;
  always @(posedge CLK) begin
    if (RST) begin
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
    end else if (serial && (rd_fall || wr_rise)) begin
      cnt_r <= 4'h0;
    end else if (serial && ex_fall) begin
      if (!rd_n) begin
        // shift read byte out LSB first
        if (cnt_r != `MHCP_BITS_PER_BYTE) begin
          cnt_r <= cnt_r + 4'h1;
        end
      end else begin
        // shift write byte in LSB first
        sh_r <= {bus_s[7], sh_r[7:1]};
        if (cnt_r != `MHCP_BITS_PER_BYTE) begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
  // store on write rise when selected
  assign we = wr_rise & (serial | ~csl_r);
  assign wdata = serial ? sh_r : bus_s;
  assign soft_clr = ifc_q[`MHCP_B_SWRST];
  mhcp_regfile u_rf (
    .clk(CLK),
    .rst(RST),
    .soft_clr(soft_clr),
    .we(we),
    .waddr(raddr),
    .wdata(wdata),
    .raddr(raddr),
    .det_in(DET_IN),
    .rdata(rdata),
    .line_q(line_q),
    .ifc_q(ifc_q),
    .tone_q(tone_q),
    .gain_q(gain_q)
  );
  // serial data pin drives only in reads
  always @(posedge CLK) begin
    if (RST) begin
      BUS_O <= 8'h00;
    end else if (serial) begin
      BUS_O <= {rdata[cnt_r[2:0]], 7'h00};
    end else begin
      BUS_O <= rdata;
    end
  end
  // no drive unless selected; read and select low
  assign BUS_OE = serial ? {~rd_n & (cnt_r != `MHCP_BITS_PER_BYTE), 7'h00}
                  : {8{~rd_n & ~csl_r & ale_s[1] == 1'b0}};
  assign det_chg = (DET_IN ^ det_d) & `MHCP_DET_IRQ_MASK;
  assign det_read = rd_fall & (serial | ~csl_r) &
                    (raddr == `MHCP_A_DET);
  // held until detect read or software reset; a new change wins over the clear
  always @(posedge CLK) begin
    if (RST) begin
      det_d <= 8'h00;
      int_r <= 1'b0;
    end else begin
      det_d <= DET_IN;
      if (ifc_q[`MHCP_B_DETIE] && |det_chg) begin
        int_r <= 1'b1;
      end else if (det_read || soft_clr) begin
        int_r <= 1'b0;
      end
    end
  end
  assign INT_OE = int_r;
  // relay pin follows hook bit
  assign HOOK_OE = gain_q[`MHCP_B_HOOK];
  // tone select; TONE_ON gated by transmit enable, TONE_CODE not gated
  always @(posedge CLK) begin
    if (RST) begin
      TONE_ON <= 1'b0;
      TONE_CODE <= 4'h0;
    end else begin
      TONE_ON <= tone_q[`MHCP_B_DTMF] & line_q[`MHCP_B_TXEN];
      TONE_CODE <= tone_q[3:0];
    end
  end
  // 16x clock only in phase modes, else crystal
  assign CLK_OUT = (ifc_q[`MHCP_B_CLKSEL] &
                    ~line_q[`MHCP_B_TM2]) ? clk16_r : xt_s[1];
  assign tmode = line_q[`MHCP_B_TM2+1:`MHCP_B_TM0];
  // bit clocks from dividers or external sources
  always @(posedge CLK) begin
    if (RST) begin
      div16_r <= 16'h0000;
      bit_r <= 16'h0000;
      clk16_r <= 1'b0;
      TX_BIT_CLK <= 1'b0;
      RX_BIT_CLK <= 1'b0;
    end else begin
      div16_r <= (div16_r == `MHCP_DIV16_HALF) ? 16'h0000 :
                 div16_r + 16'h0001;
      if (div16_r == `MHCP_DIV16_HALF) begin
        clk16_r <= ~clk16_r;
      end
      bit_r <= (bit_r == `MHCP_BIT_HALF) ? 16'h0000 : bit_r + 16'h0001;
      if (!DET_IN[`MHCP_B_CARR]) begin
        RX_BIT_CLK <= 1'b0;
      end else if (bit_r == `MHCP_BIT_HALF) begin
        RX_BIT_CLK <= ~RX_BIT_CLK;
      end
      if (tmode == `MHCP_TM_EXT) begin
        TX_BIT_CLK <= ex;
      end else if (tmode == `MHCP_TM_SLAVE) begin
        TX_BIT_CLK <= RX_BIT_CLK;
      end else if (bit_r == `MHCP_BIT_HALF) begin
        TX_BIT_CLK <= ~TX_BIT_CLK;
      end
    end
  end
  // external timing sample; otherwise at own rise
  always @(posedge CLK) begin
    if (RST) begin
      TXD_SAMPLE <= 1'b1;
    end else if (tmode == `MHCP_TM_EXT ? ex_rise :
                 (~TX_BIT_CLK & bit_r == `MHCP_BIT_HALF)) begin
      TXD_SAMPLE <= txd_s[1];
    end
  end
  // mark without carrier; change on clock fall
  always @(posedge CLK) begin
    if (RST) begin
      RXD <= 1'b1;
    end else if (!DET_IN[`MHCP_B_CARR]) begin
      RXD <= 1'b1;
    end else if (RX_BIT_CLK && bit_r == `MHCP_BIT_HALF) begin
      RXD <= rxb_s[1];
    end
  end
endmodule

/* File: core/mhcp_regfile.v */
`timescale 1ns/1ns
`include "mhcp_regs.vh"
// Eight-byte register store with registered read data
module mhcp_regfile (
  input wire clk,        // System clock
  input wire rst,        // Sync reset
  input wire soft_clr,   // Clear control bytes
  input wire we,         // Write strobe
  input wire [2:0] waddr,// Write index
  input wire [7:0] wdata,// Write data
  input wire [2:0] raddr,// Read index
  input wire [7:0] det_in,// Live detect byte
  output reg [7:0] rdata,// Registered read data
  output wire [7:0] line_q,// Line control byte
  output wire [7:0] ifc_q, // Interface control byte
  output wire [7:0] tone_q,// Tone byte
  output wire [7:0] gain_q // Gain byte
);
  reg [7:0] mem_r [0:7];
  integer i;
  assign line_q = mem_r[`MHCP_A_LINE];
  assign ifc_q = mem_r[`MHCP_A_IFC];
  assign tone_q = mem_r[`MHCP_A_TONE];
  assign gain_q = mem_r[`MHCP_A_GAIN];
  always @(posedge clk) begin
    if (rst || soft_clr) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem_r[i] <= `MHCP_RST_BYTE;
      end
      // Gain attenuation bit D2 survives a software reset
      if (!rst) begin
        mem_r[`MHCP_A_GAIN] <= mem_r[`MHCP_A_GAIN] & `MHCP_GAIN_KEEP;
        mem_r[`MHCP_A_DSP] <= mem_r[`MHCP_A_DSP];
      end
    end else if (we && waddr != `MHCP_A_DET &&
                 waddr != `MHCP_A_PART) begin
      mem_r[waddr] <= wdata;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      rdata <= `MHCP_RST_BYTE;
    end else if (raddr == `MHCP_A_DET) begin
      rdata <= det_in;
    end else if (raddr == `MHCP_A_PART) begin
      rdata <= `MHCP_PART_CODE;
    end else begin
      rdata <= mem_r[raddr];
    end
  end
endmodule

/* File: core/mhcp_regs.vh */
`ifndef MHCP_REGS_VH
`define MHCP_REGS_VH
// Register indices on the three select lines
`define MHCP_A_LINE 3'h0
`define MHCP_A_IFC 3'h1
`define MHCP_A_DET 3'h2
`define MHCP_A_TONE 3'h3
`define MHCP_A_DSP 3'h4
`define MHCP_A_GAIN 3'h5
`define MHCP_A_PART 3'h6
`define MHCP_A_SPARE 3'h7
// Field positions
`define MHCP_B_TXEN 1
`define MHCP_B_ANS 0
`define MHCP_B_SWRST 2
`define MHCP_B_CLKSEL 3
`define MHCP_B_DETIE 5
`define MHCP_B_DTMF 4
`define MHCP_B_HOOK 5
`define MHCP_B_CARR 3
`define MHCP_B_MODT1 6
`define MHCP_B_MODT0 5
`define MHCP_B_TM2 4
`define MHCP_B_TM0 2
// Reset values and fixed patterns
`define MHCP_RST_BYTE 8'h00
`define MHCP_GAIN_KEEP 8'h04
`define MHCP_DET_IRQ_MASK 8'h5E
// Part code: upper nibble arbitrary, low bit one, rest undefined
`define MHCP_PART_CODE 8'h51
`define MHCP_BITS_PER_BYTE 4'h8
`define MHCP_BIT_LAST 3'h7
// Transmit mode codes (bits D5..D2 of the line control register)
`define MHCP_TM_EXT 4'h2
`define MHCP_TM_SLAVE 4'h3
// Baud clock dividers: half period of 16x rate and of bit rate
`define MHCP_DIV16_HALF 16'h0020
`define MHCP_BIT_HALF 16'h0200
`endif

/* File: tb/mhcp_host_bus.sv */
`timescale 1ns/1ns
// Host side of the muxed bus lines
module mhcp_host_bus (
  input wire clk, // System clock
  input wire [7:0] dev_o, // Device data
  input wire [7:0] dev_oe, // Device enables
  input wire [7:0] host_o, // Host data
  input wire [7:0] host_oe, // Host enables
  output wire [7:0] bus // Resolved lines
);
  reg [7:0] last_r = 8'h00;
  // Released lines flip each cycle so stale data never reads as valid
  always @(posedge clk)
    last_r <= bus;
  // device owns a line only while enabled
  assign bus = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) |
    (~dev_oe & ~host_oe & ~last_r);
endmodule

/* File: tb/mhcp_port_chk.sv */
`timescale 1ns/1ns
`include "mhcp_regs.vh"
module mhcp_port_chk (
  input wire CLK, // System clock
  input wire RST, // Sync reset
  input wire ALE, // Latch strobe
  input wire CS_N, // Chip select
  input wire RD_N, // Read strobe
  input wire [7:0] BUS_OE, // Bus enables
  input wire INT_OE, // Interrupt drive
  input wire [7:0] DET_IN, // Detect flags
  input wire RXD, // Receive data
  input wire RX_BIT_CLK, // Receive clock
  input wire TONE_ON // Tone keyed
);
  reg ale_d_r;
  reg cs_lat_r;
  reg [3:0] rd_age_r;
  reg [3:0] det_age_r;
  reg [7:0] det_d_r;
  wire det_hit = ((DET_IN ^ det_d_r) & `MHCP_DET_IRQ_MASK) != 8'h00;
  // Ages saturate so a long idle never wraps back to recent
  always @(posedge CLK) begin
    if (RST) begin
      ale_d_r <= 1'b0;
      det_d_r <= DET_IN;
      cs_lat_r <= 1'b1;
      rd_age_r <= 4'hF;
      det_age_r <= 4'hF;
    end else begin
      ale_d_r <= ALE;
      det_d_r <= DET_IN;
      if (ale_d_r && !ALE)
        cs_lat_r <= CS_N;
      if (!RD_N)
        rd_age_r <= 4'h0;
      else if (rd_age_r != 4'hF)
        rd_age_r <= rd_age_r + 4'h1;
      if (det_hit)
        det_age_r <= 4'h0;
      else if (det_age_r != 4'hF)
        det_age_r <= det_age_r + 4'h1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  bus_drive_rd_a: assert property (
    BUS_OE != 8'h00 |-> rd_age_r < 4'h6)
    else $error("bus driven without read strobe");
  unsel_quiet_a: assert property (
    (!ALE && cs_lat_r) [*8] |-> BUS_OE == 8'h00)
    else $error("bus driven while unselected");
  serial_line_a: assert property (
    (ALE && !CS_N) [*4] |-> BUS_OE[6:0] == 7'h00)
    else $error("serial mode drives address lines");
  no_carr_mark_a: assert property (
    (!DET_IN[`MHCP_B_CARR]) [*4] |-> RXD)
    else $error("receive data not mark without carrier");
  int_hold_a: assert property (
    (RD_N [*5]) ##0 INT_OE |=> INT_OE)
    else $error("interrupt dropped without detect read");
  int_cause_a: assert property (
    $rose(INT_OE) |-> det_age_r < 4'h5)
    else $error("interrupt without detect change");
  // Reset is the trigger here, so the default disable must not apply
  reset_quiet_a: assert property (@(posedge CLK) disable iff (1'b0)
    RST |=> BUS_OE == 8'h00 && !INT_OE && !TONE_ON)
    else $error("outputs active after reset");
  rx_edge_a: assert property (
    (DET_IN[`MHCP_B_CARR] [*4]) ##0 (RXD != $past(RXD))
    |-> $fell(RX_BIT_CLK))
    else $error("receive data moved off clock fall");
  cover property ((ALE && !CS_N && !RD_N) [*8]);
  cover property ($rose(INT_OE));
  cover property ($rose(TONE_ON));
endmodule
bind mhcp_port mhcp_port_chk u_chk (.*);

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`include "mhcp_regs.vh"
module testbench;
  reg CLK, RST, ALE, CS_N, RD_N, WR_N, EXT_CLK, XTAL_CLK, RX_BIT_IN, TXD;
  reg [7:0] h_d, h_oe, DET_IN, got, exp;
  wire [7:0] bus_o, bus_oe, bus;
  wire int_oe, hook_oe, rxd, rx_clk, tone_on;
  wire clk_out, txd_smp, tx_clk;
  wire [3:0] tone_code;
  integer err_count, cmp_count, i, k;
  mhcp_port u_dut (.CLK(CLK), .RST(RST), .ALE(ALE), .CS_N(CS_N),
    .RD_N(RD_N), .WR_N(WR_N), .BUS_I(bus), .BUS_O(bus_o),
    .BUS_OE(bus_oe), .EXT_CLK(EXT_CLK), .XTAL_CLK(XTAL_CLK),
    .CLK_OUT(clk_out), .INT_OE(int_oe), .DET_IN(DET_IN),
    .HOOK_OE(hook_oe), .TXD(TXD), .TXD_SAMPLE(txd_smp),
    .TX_BIT_CLK(tx_clk),
    .RX_BIT_IN(RX_BIT_IN), .RXD(rxd), .RX_BIT_CLK(rx_clk),
    .TONE_ON(tone_on), .TONE_CODE(tone_code));
  mhcp_host_bus u_bus (.clk(CLK), .dev_o(bus_o), .dev_oe(bus_oe),
    .host_o(h_d), .host_oe(h_oe), .bus(bus));
  task cyc(input integer n);
    begin
      repeat (n) @(posedge CLK);
      #1;
    end
  endtask
  task check(input [7:0] seen, input [7:0] want, input [63:0] nm);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== want) begin
        err_count = err_count + 1;
        $display("mismatch %0s exp %h seen %h", nm, want, seen);
      end
    end
  endtask
  task conclude;
    begin
      if (err_count == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // address and select ride the latch strobe fall
  task pacc(input [2:0] a, input wr, input cs_n, input [7:0] d);
    begin
      ALE = 1'b1;
      CS_N = cs_n;
      h_d = {5'h00, a};
      h_oe = 8'hFF;
      cyc(4);
      ALE = 1'b0;
      cyc(4);
      h_d = d;
      h_oe = {8{wr}};
      if (wr)
        WR_N = 1'b0;
      else
        RD_N = 1'b0;
      cyc(8);
      got = bus;
      WR_N = 1'b1;
      RD_N = 1'b1;
      cyc(8);
    end
  endtask
  // serial frame, select lines held throughout
  task sacc(input [2:0] a, input wr, input [7:0] d, input integer n);
    begin
      ALE = 1'b1;
      CS_N = 1'b0;
      h_d = {5'h00, a};
      h_oe = {wr, 7'h07};
      RD_N = wr;
      cyc(8);
      for (k = 0; k < n; k = k + 1) begin
        got[k] = bus[7];
        h_d[7] = d[k];
        EXT_CLK = 1'b1;
        cyc(3);
        EXT_CLK = 1'b0;
        cyc(5);
      end
      WR_N = !wr;
      cyc(6);
      WR_N = 1'b1;
      RD_N = 1'b1;
      cyc(8);
    end
  endtask
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial begin
    XTAL_CLK = 1'b0;
    RX_BIT_IN = 1'b0;
    forever #45 XTAL_CLK = ~XTAL_CLK;
  end
  always #700 RX_BIT_IN = ~RX_BIT_IN;
  initial begin
    #1000000;
    err_count = err_count + 1;
    conclude;
  end
  initial begin
    {RST, ALE, CS_N, RD_N, WR_N, EXT_CLK} = 6'h2E;
    {h_d, h_oe, DET_IN} = 24'h000000;
    TXD = 1'b0;
    err_count = 0;
    cmp_count = 0;
    cyc(2);
    RST = 1'b0;
    cyc(3);
    for (i = 0; i < 8; i = i + 1)
      pacc(i[2:0], 1'b1, 1'b0, {5'h04, i[2:0]});
    for (i = 0; i < 8; i = i + 1) begin
      pacc(i[2:0], 1'b0, 1'b0, 8'h00);
      exp = i == 2 ? 8'h00 : i == 6 ? `MHCP_PART_CODE : {5'h04, i[2:0]};
      check(got, exp, "regmap");
    end
    check({7'h00, hook_oe}, 8'h01, "hook");
    pacc(3'h3, 1'b1, 1'b0, 8'h1A);
    check({7'h00, tone_on}, 8'h00, "tonegate");
    pacc(3'h0, 1'b1, 1'b0, 8'h02);
    for (i = 0; i < 16; i = i + 1) begin
      pacc(3'h3, 1'b1, 1'b0, {4'h1, i[3:0]});
      check({3'h0, tone_on, tone_code}, {4'h1, i[3:0]}, "tone");
    end
    pacc(3'h3, 1'b1, 1'b1, 8'h00);
    pacc(3'h3, 1'b0, 1'b1, 8'h00);
    pacc(3'h3, 1'b0, 1'b0, 8'h00);
    check(got, 8'h1F, "unsel");
    pacc(3'h1, 1'b1, 1'b0, 8'h29);
    pacc(3'h0, 1'b1, 1'b0, 8'h08); // reserved bits left zero
    got[0] = clk_out;
    cyc(33);
    check({7'h00, clk_out}, {7'h00, ~got[0]}, "clk16");
    cyc(2);
    EXT_CLK = 1'b1;
    cyc(8);
    check({7'h00, txd_smp}, 8'h00, "extsmp0");
    EXT_CLK = 1'b0;
    // data set up well ahead of the clock rise
    TXD = 1'b1;
    cyc(4);
    EXT_CLK = 1'b1;
    cyc(8);
    check({6'h00, txd_smp, tx_clk}, 8'h03, "extsmp1");
    EXT_CLK = 1'b0;
    cyc(4);
    DET_IN = 8'h01;
    cyc(8);
    check({7'h00, int_oe}, 8'h00, "masked");
    DET_IN = 8'h09;
    cyc(30);
    check({7'h00, int_oe}, 8'h01, "intset");
    pacc(3'h2, 1'b0, 1'b0, 8'h00);
    check(got, 8'h09, "detect");
    check({7'h00, int_oe}, 8'h00, "intclr");
    cyc(2600);
    DET_IN = 8'h00;
    cyc(6);
    check({6'h00, rxd, rx_clk}, 8'h02, "mark");
    sacc(3'h3, 1'b1, 8'h15, 8);
    sacc(3'h3, 1'b0, 8'h00, 3);
    sacc(3'h3, 1'b0, 8'h00, 8);
    check(got, 8'h15, "serial");
    sacc(3'h5, 1'b1, 8'h00, 8);
    check({7'h00, hook_oe}, 8'h00, "hookoff");
    RST = 1'b1;
    cyc(2);
    RST = 1'b0;
    cyc(3);
    for (i = 0; i < 4; i = i + 1) begin
      pacc(i[2:0] ^ 3'h2, 1'b0, 1'b0, 8'h00);
      if (i != 0)
        check(got, 8'h00, "rstclr");
    end
    conclude;
  end
endmodule
